// [cpwt_pkg.sv]
/*
 * Package for the cascaded pulse generator / warm-up timer.
 * Holds the APB register map, control field positions, reset values and modes.
 * Assumes a single pclk domain at 125 MHz.
 */
package cpwt_pkg;
    // Register byte addresses
    localparam logic [7:0] CPWT_PW_LOW_ADDR   = 8'h00;
    localparam logic [7:0] CPWT_PW_HIGH_ADDR  = 8'h04;
    localparam logic [7:0] CPWT_PER_LOW_ADDR  = 8'h08;
    localparam logic [7:0] CPWT_PER_HIGH_ADDR = 8'h0C;
    localparam logic [7:0] CPWT_LOW_CTRL_ADDR = 8'h10;
    localparam logic [7:0] CPWT_UP_CTRL_ADDR  = 8'h14;
    localparam logic [7:0] CPWT_STAT_ADDR     = 8'h18;
    localparam logic [7:0] CPWT_CLR_ADDR      = 8'h1C;
    localparam logic [7:0] CPWT_IEN_ADDR      = 8'h20;
    localparam logic [7:0] CPWT_CNT_ADDR      = 8'h24;

    // Upper control fields
    localparam int CPWT_RUN_BIT  = 3;
    localparam int CPWT_TFF_BIT  = 7;
    localparam int CPWT_MODE_LSB = 0;
    localparam int CPWT_MODE_W   = 3;
    // Lower control fields
    localparam int CPWT_SRC_LSB  = 0;
    localparam int CPWT_SRC_W    = 3;

    localparam logic [2:0] CPWT_MODE_PPG    = 3'h7;
    localparam logic [2:0] CPWT_MODE_WARMUP = 3'h5;
    localparam logic [2:0] CPWT_SRC_EXT     = 3'h7;

    localparam logic [7:0]  CPWT_BYTE_RST = 8'hFF;
    localparam logic [7:0]  CPWT_CTRL_RST = 8'h00;
    localparam logic [15:0] CPWT_CNT_ZERO = 16'h0000;
    localparam logic [15:0] CPWT_CNT_ONE  = 16'h0001;

    // Prescaler taps of pclk for internal sources 0..6
    localparam int CPWT_PRE_W = 12;

    typedef enum logic [1:0] {CPWT_IDLE, CPWT_RUN} cpwt_state_t;
endpackage

// [cpwt_tick_if.sv]
/*
 * Interface carrying the count-enable tick between the clock selector and the timer.
 * Assumes both ends on pclk.
 */
`timescale 1ns/1ns
interface cpwt_tick_if;
    logic       tick;
    logic [2:0] src_sel;
    modport sel (output tick, input src_sel);
    modport tmr (input tick, output src_sel);
endinterface

// [cpwt_clk_sel.sv]
/*
 * Count-clock selector: prescaled pclk taps or falling edges of the external input.
 * Assumes the external input is asynchronous and slow (at least two machine cycles per level).
 */
`timescale 1ns/1ns
module cpwt_clk_sel
    import cpwt_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // External count pin
    input  wire logic ext_in,
    // Tick carrier
    cpwt_tick_if.sel  tk
);
    logic [CPWT_PRE_W-1:0] pre_q;
    logic [2:0]            sync_q;
    logic [3:0]            tap_idx;
    logic                  pre_tick;
    logic                  ext_fall;

    // Source code selects a prescaler tap: 0 -> /2^11 .. 6 -> /1
    assign tap_idx  = (tk.src_sel == 3'h0) ? 4'hB :
                      (tk.src_sel == 3'h1) ? 4'h7 :
                      (tk.src_sel == 3'h2) ? 4'h5 :
                      (tk.src_sel == 3'h3) ? 4'h3 :
                      (tk.src_sel == 3'h4) ? 4'h4 :
                      (tk.src_sel == 3'h5) ? 4'h1 : 4'h0;
    assign pre_tick = (tap_idx == 4'h0) ? 1'b1
                    : (pre_q & ((12'h001 << tap_idx) - 12'h001)) == 12'h000;
    // Only the second and third stages feed the edge detector
    assign ext_fall = sync_q[1] == 1'b0 && sync_q[2] == 1'b1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q  <= 12'h000;
            sync_q <= 3'h0;
            tk.tick <= 1'b0;
        end
        else
        begin
            pre_q  <= pre_q + 12'h001;
            sync_q <= {sync_q[1:0], ext_in};
            tk.tick <= (tk.src_sel == CPWT_SRC_EXT) ? ext_fall : pre_tick;  // see R03
        end
    end
endmodule // cpwt_clk_sel

// [cpwt_timer.sv]
/*
 * Cascaded 16-bit pulse generator / warm-up timer with APB registers.
 * Assumes one pclk domain, an APB master, and an asynchronous external count pin.
 */
//
// Contract
// R01 - PPG: toggle output on pulse-width match
// R02 - PPG: period match toggles, clears, interrupts
// R03 - External count levels last two cycles
// R04 - Flop loads initial level; reset clears
// R05 - Output pin is inverse of flop
// R06 - Software writes compare low then high
// R07 - Software sets shared port latch first
// R08 - No compare shadow; writes act at once
// R09 - Stop holds pin; level written later
// R10 - Run bit 3 starts and stops timer
// R11 - Warm-up compares only upper period byte
// R12 - Warm-up: software keeps initial level zero
// R13 - Warm-up match clears counter, interrupts
// R14 - Low-frequency switch sequence by software
// R15 - High-frequency switch sequence by software
// R16 - Warm-up setting 0100H to FF00H
// R17 - Counter starts at zero, carries cascaded
`timescale 1ns/1ns
module cpwt_timer
    import cpwt_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        external_count_input,
    output logic             pulse_gen_output_pin,
    // Interrupt
    output logic             irq
);
    import cpwt_pkg::*;

    cpwt_tick_if tk ();

    logic [7:0]  pw_lo_q, pw_hi_q, per_lo_q, per_hi_q;
    logic [7:0]  lctl_q, uctl_q;
    logic [15:0] cnt_q, cnt_d;
    logic        tff_q, tff_d;
    logic        stat_q, ien_q;
    logic        run_q;
    cpwt_state_t st_q;

    logic        wr_en, rd_en, addr_ok;
    logic        run_bit, tff_bit, run_rise, counting;
    logic [2:0]  mode;
    logic        is_ppg, is_warm;
    logic [15:0] pw_cmp, per_cmp;
    logic        pw_hit, per_hit, warm_hit, match_ev;
    logic        run_wr_clear, tff_wr;
    logic [31:0] rd_d;

    cpwt_clk_sel u_sel (
        .pclk    (pclk),
        .presetn (presetn),
        .ext_in  (external_count_input),
        .tk      (tk.sel)
    );

    // Bus decode; each access completes in its first access cycle
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign addr_ok = paddr == CPWT_PW_LOW_ADDR  || paddr == CPWT_PW_HIGH_ADDR ||
                     paddr == CPWT_PER_LOW_ADDR || paddr == CPWT_PER_HIGH_ADDR ||
                     paddr == CPWT_LOW_CTRL_ADDR || paddr == CPWT_UP_CTRL_ADDR ||
                     paddr == CPWT_STAT_ADDR    || paddr == CPWT_CLR_ADDR ||
                     paddr == CPWT_IEN_ADDR     || paddr == CPWT_CNT_ADDR;

    assign tk.src_sel = lctl_q[CPWT_SRC_LSB +: CPWT_SRC_W];
    assign run_bit    = uctl_q[CPWT_RUN_BIT];                            // see R10
    assign tff_bit    = uctl_q[CPWT_TFF_BIT];
    assign mode       = uctl_q[CPWT_MODE_LSB +: CPWT_MODE_W];
    assign is_ppg     = mode == CPWT_MODE_PPG;
    assign is_warm    = mode == CPWT_MODE_WARMUP;
    assign run_rise   = run_bit && !run_q;

    // Compare values read live from the registers, no shadow stage  see R08
    assign pw_cmp   = {pw_hi_q, pw_lo_q};
    assign per_cmp  = {per_hi_q, per_lo_q};
    // The state lags the run bit by one edge, so a stopping write must not let
    // one more match through in that edge  see R09
    assign counting = run_bit && st_q == CPWT_RUN;
    assign pw_hit   = is_ppg && counting && tk.tick
                      && cnt_d == pw_cmp;                                 // see R01
    assign per_hit  = is_ppg && counting && tk.tick
                      && cnt_d == per_cmp;                                // see R02
    // Lower period byte plays no part in warm-up matching  see R11 see R16
    assign warm_hit = is_warm && counting && tk.tick
                      && cnt_d[15:8] == per_hi_q;                         // see R13
    assign match_ev = per_hit || warm_hit;

    // Count value after this tick; low byte carries into high byte  see R17
    always_comb
    begin
        cnt_d = cnt_q + CPWT_CNT_ONE;
    end

    // Writes of the initial level act only when the timer is stopped in both old
    // and new control value, so a stopping write cannot disturb the held level
    assign run_wr_clear = wr_en && paddr == CPWT_UP_CTRL_ADDR && !pwdata[CPWT_RUN_BIT];
    assign tff_wr       = wr_en && paddr == CPWT_UP_CTRL_ADDR && !run_bit
                          && !pwdata[CPWT_RUN_BIT];                       // see R09

    always_comb
    begin
        tff_d = tff_q;
        if (tff_wr)
            tff_d = pwdata[CPWT_TFF_BIT];                                 // see R04
        else if (pw_hit ^ per_hit)
            tff_d = ~tff_q;                                               // see R01 see R02
    end

    always_comb
    begin
        unique case (paddr)
            CPWT_PW_LOW_ADDR:   rd_d = {24'h000000, pw_lo_q};
            CPWT_PW_HIGH_ADDR:  rd_d = {24'h000000, pw_hi_q};
            CPWT_PER_LOW_ADDR:  rd_d = {24'h000000, per_lo_q};
            CPWT_PER_HIGH_ADDR: rd_d = {24'h000000, per_hi_q};
            CPWT_LOW_CTRL_ADDR: rd_d = {24'h000000, lctl_q};
            CPWT_UP_CTRL_ADDR:  rd_d = {24'h000000, uctl_q};
            CPWT_STAT_ADDR:     rd_d = {31'h00000000, stat_q};
            CPWT_IEN_ADDR:      rd_d = {31'h00000000, ien_q};
            CPWT_CNT_ADDR:      rd_d = {16'h0000, cnt_q};
            default:            rd_d = 32'h00000000;
        endcase
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pw_lo_q  <= CPWT_BYTE_RST;
            pw_hi_q  <= CPWT_BYTE_RST;
            per_lo_q <= CPWT_BYTE_RST;
            per_hi_q <= CPWT_BYTE_RST;
            lctl_q   <= CPWT_CTRL_RST;
            uctl_q   <= CPWT_CTRL_RST;
            ien_q    <= 1'b0;
        end
        else if (wr_en)
        begin
            // Each byte is its own register; software orders low then high  see R06
            if (paddr == CPWT_PW_LOW_ADDR)   pw_lo_q  <= pwdata[7:0];
            if (paddr == CPWT_PW_HIGH_ADDR)  pw_hi_q  <= pwdata[7:0];
            if (paddr == CPWT_PER_LOW_ADDR)  per_lo_q <= pwdata[7:0];
            if (paddr == CPWT_PER_HIGH_ADDR) per_hi_q <= pwdata[7:0];
            if (paddr == CPWT_LOW_CTRL_ADDR) lctl_q   <= pwdata[7:0];
            if (paddr == CPWT_UP_CTRL_ADDR)  uctl_q   <= pwdata[7:0];
            if (paddr == CPWT_IEN_ADDR)      ien_q    <= pwdata[0];
        end
    end

    // Counter, state and output flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= CPWT_CNT_ZERO;
            st_q  <= CPWT_IDLE;
            run_q <= 1'b0;
            tff_q <= 1'b0;                                                // see R04
        end
        else
        begin
            run_q <= run_bit;
            tff_q <= tff_d;
            unique case (st_q)
                CPWT_IDLE:
                    if (run_rise)
                    begin
                        cnt_q <= CPWT_CNT_ZERO;                           // see R17
                        st_q  <= CPWT_RUN;                                // see R10
                    end
                CPWT_RUN:
                    if (!run_bit)
                        st_q <= CPWT_IDLE;                                // see R10
                    else if (match_ev)
                        cnt_q <= CPWT_CNT_ZERO;                           // see R02 see R13
                    else if (tk.tick)
                        cnt_q <= cnt_d;
                default:
                    st_q <= CPWT_IDLE;
            endcase
        end
    end

    // Sticky status: set wins over clear; interrupt and bus outputs registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q  <= 1'b0;
            irq     <= 1'b0;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            pulse_gen_output_pin <= 1'b1;
        end
        else
        begin
            if (match_ev)
                stat_q <= 1'b1;                                           // see R02 see R13
            else if (wr_en && paddr == CPWT_CLR_ADDR && pwdata[0])
                stat_q <= 1'b0;
            irq     <= (stat_q || match_ev) && ien_q;
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            // Zero outside reads keeps a refused write reply clean
            prdata  <= rd_en ? rd_d : 32'h00000000;
            pulse_gen_output_pin <= ~tff_d;                               // see R05
        end
    end
endmodule // cpwt_timer

// [cpwt_timer_properties.sv]
/* Port checker for cpwt_timer: APB timing, error replies, reset levels, masking.
   Assumes one pclk domain and is attached by the bind below. */
`timescale 1ns/1ns
module cpwt_timer_properties
    import cpwt_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and interrupt
    input wire logic        external_count_input,
    input wire logic        pulse_gen_output_pin,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;

    a_ready_in_access: assert property (acc |-> pready)
        else $error("no ready in access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_has_cause: assert property (pready |-> acc)
        else $error("ready outside access phase");
    a_err_on_unmapped: assert property (pready && paddr > CPWT_CNT_ADDR |-> pslverr)
        else $error("unmapped access not refused");
    a_no_err_mapped: assert property (pready && paddr <= CPWT_CNT_ADDR
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error reply not clean");
    a_pin_after_reset: assert property ($rose(presetn) |-> pulse_gen_output_pin)
        else $error("pin not high after reset");
    a_irq_after_reset: assert property ($rose(presetn) |-> !irq)
        else $error("irq high after reset");
    a_irq_masked_off: assert property (acc && pwrite && paddr == CPWT_IEN_ADDR
        && !pwdata[0] |-> ##[1:2] !irq)
        else $error("irq not masked");

    c_irq_raised: cover property ($rose(irq));
    c_pin_toggled: cover property ($fell(pulse_gen_output_pin));
    c_refused: cover property (pready && pslverr);
endmodule // cpwt_timer_properties

bind cpwt_timer cpwt_timer_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(external_count_input),
    .pulse_gen_output_pin(pulse_gen_output_pin), .irq(irq)
);

// [cpwt_timer_bench.sv]
/* Self-checking bench for cpwt_timer: APB master, pulse runs, warm-up, count pin.
   Assumes the port checker is bound from its own file. */
`timescale 1ns/1ns
module cpwt_timer_bench;
    import cpwt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, ext_in;
    logic        pready, pslverr, pin, irq, err_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q, lfsr_q;
    int          bad_count, tests_run, n, lo, hi, pw, per;

    cpwt_timer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_input(ext_in),
        .pulse_gen_output_pin(pin), .irq(irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until pready; one idle edge after keeps psel from double driving
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_q  = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(what, rd_q, exp);
    endtask

    task automatic runlen(output int len);
        logic v;
        v = pin;
        len = 0;
        while (pin === v && len < 5000)
        begin
            @(posedge pclk);
            len++;
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (10000) @(posedge pclk);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        {psel, penable, pwrite, ext_in} = 4'b0001;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        bad_count = 0;
        tests_run = 0;
        lfsr_q    = 32'hED99;
        presetn   = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pin_reset", pin, 32'h1);
        rdc("pw_low_reset", CPWT_PW_LOW_ADDR, 32'hFF);
        rdc("ctrl_reset", CPWT_UP_CTRL_ADDR, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        chk("unmapped_err", err_q, 32'h1);
        $display("test done: reset and map");
        apb(CPWT_IEN_ADDR, 1'b1, 32'h1);
        apb(CPWT_LOW_CTRL_ADDR, 1'b1, 32'h6);
        repeat (3)
        begin
            lfsr_q = next_rand(lfsr_q);
            pw  = 4 + lfsr_q[2:0];
            per = pw + 4 + lfsr_q[6:4];
            apb(CPWT_PW_LOW_ADDR, 1'b1, 32'(pw));
            apb(CPWT_PW_HIGH_ADDR, 1'b1, 32'h0);
            apb(CPWT_PER_LOW_ADDR, 1'b1, 32'(per));
            apb(CPWT_PER_HIGH_ADDR, 1'b1, 32'h0);
            apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h0F);
            runlen(n);
            runlen(lo);
            runlen(hi);
            chk("ppg_low_run", lo, 32'(per - pw));
            chk("ppg_high_run", hi, 32'(pw));
            runlen(n);
            // Pin just rose and stays high at least four ticks while the stop lands
            apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h07);
            repeat (10) @(posedge pclk);
            chk("stop_holds", pin, 32'h1);
            apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h87);
            @(posedge pclk);
            chk("level_one", pin, 32'h0);
            apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h07);
            @(posedge pclk);
            chk("level_zero", pin, 32'h1);
            rdc("ppg_status", CPWT_STAT_ADDR, 32'h1);
            apb(CPWT_CLR_ADDR, 1'b1, 32'h1);
            @(posedge pclk);
            chk("irq_cleared", irq, 32'h0);
        end
        $display("test done: pulse generator");
        lfsr_q = next_rand(lfsr_q);
        apb(CPWT_PER_LOW_ADDR, 1'b1, 32'(lfsr_q[7:0] | 8'h80));
        apb(CPWT_PER_HIGH_ADDR, 1'b1, 32'h01);
        apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h05);
        apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h0D);
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        chk("warmup_time", 32'(n >= 250 && n <= 262), 32'h1);
        apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h05);
        apb(CPWT_IEN_ADDR, 1'b1, 32'h0);
        @(posedge pclk);
        chk("irq_masked", irq, 32'h0);
        rdc("warmup_status", CPWT_STAT_ADDR, 32'h1);
        apb(CPWT_CLR_ADDR, 1'b1, 32'h1);
        rdc("status_clear", CPWT_STAT_ADDR, 32'h0);
        $display("test done: warm-up and interrupt");
        apb(CPWT_PER_LOW_ADDR, 1'b1, 32'hFF);
        apb(CPWT_PER_HIGH_ADDR, 1'b1, 32'hFF);
        // Internal taps /2 and /8: a 64-edge window holds a whole number of ticks
        for (lo = 0; lo < 2; lo++)
        begin
            n = (lo == 0) ? 2 : 8;
            apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h07);
            apb(CPWT_LOW_CTRL_ADDR, 1'b1, (lo == 0) ? 32'h5 : 32'h3);
            apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h0F);
            repeat (64) @(posedge pclk);
            rdc("tap_count", CPWT_CNT_ADDR, 32'(64 / n));
        end
        $display("test done: internal taps");
        apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h07);
        apb(CPWT_LOW_CTRL_ADDR, 1'b1, 32'h7);
        apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h0F);
        // Each level lasts eight edges, a rate of one sixteenth of pclk
        repeat (5)
        begin
            repeat (8) @(posedge pclk);
            ext_in <= 1'b0;
            repeat (8) @(posedge pclk);
            ext_in <= 1'b1;
        end
        repeat (6) @(posedge pclk);
        rdc("ext_count", CPWT_CNT_ADDR, 32'h5);
        apb(CPWT_UP_CTRL_ADDR, 1'b1, 32'h07);
        $display("test done: external count");
        give_verdict();
    end
endmodule // cpwt_timer_bench
